// >>> rtl/acmp_control.sv
// comparator input selection, result synchroniser, event flag and registers
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Overview of operation
// - raw result high when positive exceeds negative
// - result synchronised, three cycles late
// - mux enabled, converter off: channel is negative
// - channel select 000..111 picks channels 0..7
// - otherwise negative pin feeds negative input
// - power-off bit removes comparator power
// - bandgap select chooses bandgap or positive pin
// - selected event type sets event flag
// - interrupt vector execution clears event flag
// - writing one clears flag, zero keeps
// - irq needs flag, enable, global enable
// - capture route feeds result to capture
// - capture route off disconnects result completely
// - mode 00 toggle, 10 fall, 11 rise
// - input-off bit kills buffer, reads zero
// - converter enable is converter's own control
// ------------------------------------------------------------------
module acmp_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic [acmp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [acmp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [acmp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic converter_enable,
  input wire logic [acmp_pkg::CHAN_W-1:0] channel_select,
  input wire logic global_irq_enable,
  input wire logic comp_irq_vector_taken,
  input wire logic [acmp_pkg::LEVEL_W-1:0] comp_positive_pin,
  input wire logic [acmp_pkg::LEVEL_W-1:0] comp_negative_pin,
  input wire logic [acmp_pkg::LEVEL_W-1:0] bandgap_level,
  input wire logic [acmp_pkg::CHAN_N*acmp_pkg::LEVEL_W-1:0] channel_levels,
  input wire logic pos_pin_digital,
  input wire logic neg_pin_digital,
  output logic pos_pin_read,
  output logic neg_pin_read,
  output logic pos_pin_buffer_off,
  output logic neg_pin_buffer_off,
  output logic comp_power_off,
  output logic neg_channel_routed,
  output logic [acmp_pkg::CHAN_W-1:0] neg_channel,
  output logic bandgap_positive_select,
  output logic [acmp_pkg::TRIG_SRC_W-1:0] trigger_source,
  output logic comp_result,
  output logic comp_irq_req,
  output logic capture_input
);
  import acmp_pkg::*;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic neg_mux_route_enable_ff, nxt_neg_mux_route_enable;
  logic [TRIG_SRC_W-1:0] trigger_source_ff, nxt_trigger_source;
  logic comp_power_off_ff, nxt_comp_power_off;
  logic bandgap_positive_select_ff, nxt_bandgap_positive_select;
  logic comp_irq_enable_ff, nxt_comp_irq_enable;
  logic capture_route_enable_ff, nxt_capture_route_enable;
  logic [1:0] edge_mode_ff, nxt_edge_mode;
  logic pos_pin_input_off_ff, nxt_pos_pin_input_off;
  logic neg_pin_input_off_ff, nxt_neg_pin_input_off;
  logic wr_mux, wr_ctrl, wr_did;

  assign wr_mux = reg_wr && (reg_addr == OFS_MUX_TRIG_CTRL);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_COMP_CTRL_STAT);
  assign wr_did = reg_wr && (reg_addr == OFS_DIG_IN_DISABLE);

  always_comb begin
    nxt_neg_mux_route_enable = neg_mux_route_enable_ff;
    nxt_trigger_source = trigger_source_ff;
    nxt_comp_power_off = comp_power_off_ff;
    nxt_bandgap_positive_select = bandgap_positive_select_ff;
    nxt_comp_irq_enable = comp_irq_enable_ff;
    nxt_capture_route_enable = capture_route_enable_ff;
    nxt_edge_mode = edge_mode_ff;
    nxt_pos_pin_input_off = pos_pin_input_off_ff;
    nxt_neg_pin_input_off = neg_pin_input_off_ff;
    if (wr_mux) begin
      nxt_neg_mux_route_enable = reg_wdata[BIT_NEG_MUX_ROUTE_EN];
      nxt_trigger_source = reg_wdata[BIT_TRIG_SRC_LSB +: TRIG_SRC_W];
    end
    if (wr_ctrl) begin
      nxt_comp_power_off = reg_wdata[BIT_COMP_POWER_OFF];
      nxt_bandgap_positive_select = reg_wdata[BIT_BANDGAP_POS_SEL];
      nxt_comp_irq_enable = reg_wdata[BIT_COMP_IRQ_EN];
      nxt_capture_route_enable = reg_wdata[BIT_CAPTURE_ROUTE_EN];
      nxt_edge_mode = {reg_wdata[BIT_EDGE_MODE_HI], reg_wdata[BIT_EDGE_MODE_LO]};
    end
    if (wr_did) begin
      nxt_pos_pin_input_off = reg_wdata[BIT_POS_PIN_INPUT_OFF];
      nxt_neg_pin_input_off = reg_wdata[BIT_NEG_PIN_INPUT_OFF];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      neg_mux_route_enable_ff <= RST_MUX_TRIG_CTRL[BIT_NEG_MUX_ROUTE_EN];
      trigger_source_ff <= RST_MUX_TRIG_CTRL[BIT_TRIG_SRC_LSB +: TRIG_SRC_W];
      comp_power_off_ff <= RST_COMP_CTRL_STAT[BIT_COMP_POWER_OFF];
      bandgap_positive_select_ff <= RST_COMP_CTRL_STAT[BIT_BANDGAP_POS_SEL];
      comp_irq_enable_ff <= RST_COMP_CTRL_STAT[BIT_COMP_IRQ_EN];
      capture_route_enable_ff <= RST_COMP_CTRL_STAT[BIT_CAPTURE_ROUTE_EN];
      edge_mode_ff <= RST_COMP_CTRL_STAT[BIT_EDGE_MODE_HI:BIT_EDGE_MODE_LO];
      pos_pin_input_off_ff <= RST_DIG_IN_DISABLE[BIT_POS_PIN_INPUT_OFF];
      neg_pin_input_off_ff <= RST_DIG_IN_DISABLE[BIT_NEG_PIN_INPUT_OFF];
    end else begin
      neg_mux_route_enable_ff <= nxt_neg_mux_route_enable;
      trigger_source_ff <= nxt_trigger_source;
      comp_power_off_ff <= nxt_comp_power_off;
      bandgap_positive_select_ff <= nxt_bandgap_positive_select;
      comp_irq_enable_ff <= nxt_comp_irq_enable;
      capture_route_enable_ff <= nxt_capture_route_enable;
      edge_mode_ff <= nxt_edge_mode;
      pos_pin_input_off_ff <= nxt_pos_pin_input_off;
      neg_pin_input_off_ff <= nxt_neg_pin_input_off;
    end
  end

  // ----------------------------------------------------------------
  // input selection, comparison and synchroniser
  // ----------------------------------------------------------------
  logic route_channel;
  logic [LEVEL_W-1:0] pos_level, neg_level;
  logic raw_ff, nxt_raw;
  logic sync_meta_ff, comp_result_ff, prev_result_ff;
  logic neg_channel_routed_ff, nxt_neg_channel_routed;
  logic [CHAN_W-1:0] neg_channel_ff, nxt_neg_channel;

  // converter_enable is the converter's own enable control
  assign route_channel = neg_mux_route_enable_ff && !converter_enable;

  always_comb begin
    pos_level = comp_positive_pin;
    if (bandgap_positive_select_ff) begin
      pos_level = bandgap_level;
    end
    neg_level = comp_negative_pin;
    nxt_neg_channel_routed = 1'b0;
    nxt_neg_channel = neg_channel_ff;
    if (route_channel) begin
      neg_level = channel_levels[channel_select*LEVEL_W +: LEVEL_W];
      nxt_neg_channel_routed = 1'b1;
      nxt_neg_channel = channel_select;
    end
    // powered-down comparator gives a steady low
    nxt_raw = 1'b0;
    if (!comp_power_off_ff) begin
      nxt_raw = (pos_level > neg_level);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      raw_ff <= 1'b0;
      sync_meta_ff <= 1'b0;
      comp_result_ff <= 1'b0;
      prev_result_ff <= 1'b0;
      neg_channel_routed_ff <= 1'b0;
      neg_channel_ff <= '0;
    end else begin
      raw_ff <= nxt_raw;
      sync_meta_ff <= raw_ff;
      comp_result_ff <= sync_meta_ff;
      prev_result_ff <= comp_result_ff;
      neg_channel_routed_ff <= nxt_neg_channel_routed;
      neg_channel_ff <= nxt_neg_channel;
    end
  end

  // ----------------------------------------------------------------
  // event detection, flag and interrupt request
  // ----------------------------------------------------------------
  logic rise_evt, fall_evt, event_hit;
  logic comp_event_flag_ff, nxt_comp_event_flag;
  logic comp_irq_req_ff, nxt_comp_irq_req;
  logic capture_input_ff, nxt_capture_input;

  assign rise_evt = comp_result_ff && !prev_result_ff;
  assign fall_evt = !comp_result_ff && prev_result_ff;

  always_comb begin
    case (edge_mode_ff)
      MODE_TOGGLE: event_hit = rise_evt || fall_evt;
      MODE_FALLING: event_hit = fall_evt;
      MODE_RISING: event_hit = rise_evt;
      MODE_RESERVED: event_hit = 1'b0;
      default: event_hit = 1'b0;
    endcase
    nxt_comp_event_flag = comp_event_flag_ff;
    if (comp_irq_vector_taken) begin
      nxt_comp_event_flag = 1'b0;
    end
    if (wr_ctrl && reg_wdata[BIT_COMP_EVENT_FLAG]) begin
      nxt_comp_event_flag = 1'b0;
    end
    // a new event outranks any clear in the same cycle
    if (event_hit) begin
      nxt_comp_event_flag = 1'b1;
    end
    nxt_comp_irq_req = nxt_comp_event_flag && nxt_comp_irq_enable && global_irq_enable;
    nxt_capture_input = 1'b0;
    if (capture_route_enable_ff) begin
      nxt_capture_input = comp_result_ff;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      comp_event_flag_ff <= RST_COMP_CTRL_STAT[BIT_COMP_EVENT_FLAG];
      comp_irq_req_ff <= 1'b0;
      capture_input_ff <= 1'b0;
    end else begin
      comp_event_flag_ff <= nxt_comp_event_flag;
      comp_irq_req_ff <= nxt_comp_irq_req;
      capture_input_ff <= nxt_capture_input;
    end
  end

  // ----------------------------------------------------------------
  // pin read gating
  // ----------------------------------------------------------------
  logic pos_pin_read_ff, nxt_pos_pin_read;
  logic neg_pin_read_ff, nxt_neg_pin_read;

  always_comb begin
    nxt_pos_pin_read = pos_pin_digital && !nxt_pos_pin_input_off;
    nxt_neg_pin_read = neg_pin_digital && !nxt_neg_pin_input_off;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_pin_read_ff <= 1'b0;
      neg_pin_read_ff <= 1'b0;
    end else begin
      pos_pin_read_ff <= nxt_pos_pin_read;
      neg_pin_read_ff <= nxt_neg_pin_read;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_MUX_TRIG_CTRL: begin
          nxt_rdata[BIT_NEG_MUX_ROUTE_EN] = neg_mux_route_enable_ff;
          nxt_rdata[BIT_TRIG_SRC_LSB +: TRIG_SRC_W] = trigger_source_ff;
        end
        OFS_COMP_CTRL_STAT: begin
          nxt_rdata[BIT_COMP_POWER_OFF] = comp_power_off_ff;
          nxt_rdata[BIT_BANDGAP_POS_SEL] = bandgap_positive_select_ff;
          nxt_rdata[BIT_COMP_RESULT] = comp_result_ff;
          nxt_rdata[BIT_COMP_EVENT_FLAG] = comp_event_flag_ff;
          nxt_rdata[BIT_COMP_IRQ_EN] = comp_irq_enable_ff;
          nxt_rdata[BIT_CAPTURE_ROUTE_EN] = capture_route_enable_ff;
          nxt_rdata[BIT_EDGE_MODE_HI] = edge_mode_ff[1];
          nxt_rdata[BIT_EDGE_MODE_LO] = edge_mode_ff[0];
        end
        OFS_DIG_IN_DISABLE: begin
          nxt_rdata[BIT_NEG_PIN_INPUT_OFF] = neg_pin_input_off_ff;
          nxt_rdata[BIT_POS_PIN_INPUT_OFF] = pos_pin_input_off_ff;
        end
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign pos_pin_read = pos_pin_read_ff;
  assign neg_pin_read = neg_pin_read_ff;
  assign pos_pin_buffer_off = pos_pin_input_off_ff;
  assign neg_pin_buffer_off = neg_pin_input_off_ff;
  assign comp_power_off = comp_power_off_ff;
  assign neg_channel_routed = neg_channel_routed_ff;
  assign neg_channel = neg_channel_ff;
  assign bandgap_positive_select = bandgap_positive_select_ff;
  assign trigger_source = trigger_source_ff;
  assign comp_result = comp_result_ff;
  assign comp_irq_req = comp_irq_req_ff;
  assign capture_input = capture_input_ff;

endmodule
`default_nettype wire

// >>> rtl/acmp_pkg.sv
// constants shared by the comparator control block
package acmp_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;
  localparam logic [1:0] OFS_MUX_TRIG_CTRL = 2'h0;
  localparam logic [1:0] OFS_COMP_CTRL_STAT = 2'h1;
  localparam logic [1:0] OFS_DIG_IN_DISABLE = 2'h2;

  // ----------------------------------------------------------------
  // mux_and_trigger_control fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_NEG_MUX_ROUTE_EN = 6;
  localparam int unsigned BIT_TRIG_SRC_LSB = 0;
  localparam int unsigned TRIG_SRC_W = 3;
  localparam logic [7:0] RST_MUX_TRIG_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // comparator_control_status fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_COMP_POWER_OFF = 7;
  localparam int unsigned BIT_BANDGAP_POS_SEL = 6;
  localparam int unsigned BIT_COMP_RESULT = 5;
  localparam int unsigned BIT_COMP_EVENT_FLAG = 4;
  localparam int unsigned BIT_COMP_IRQ_EN = 3;
  localparam int unsigned BIT_CAPTURE_ROUTE_EN = 2;
  localparam int unsigned BIT_EDGE_MODE_HI = 1;
  localparam int unsigned BIT_EDGE_MODE_LO = 0;
  localparam logic [7:0] RST_COMP_CTRL_STAT = 8'h00;

  // ----------------------------------------------------------------
  // digital_input_disable fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_NEG_PIN_INPUT_OFF = 1;
  localparam int unsigned BIT_POS_PIN_INPUT_OFF = 0;
  localparam logic [7:0] RST_DIG_IN_DISABLE = 8'h00;

  // ----------------------------------------------------------------
  // analog side and event modes
  // ----------------------------------------------------------------
  localparam int unsigned LEVEL_W = 10;
  localparam int unsigned CHAN_N = 8;
  localparam int unsigned CHAN_W = 3;
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALLING = 2'h2;
  localparam logic [1:0] MODE_RISING = 2'h3;

endpackage

// >>> tb/acmp_control_asserts.sv
// checker for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module acmp_control_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [acmp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [acmp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic converter_enable,
  input wire logic [acmp_pkg::CHAN_W-1:0] channel_select,
  input wire logic global_irq_enable,
  input wire logic comp_irq_vector_taken,
  input wire logic [acmp_pkg::LEVEL_W-1:0] comp_positive_pin,
  input wire logic [acmp_pkg::LEVEL_W-1:0] comp_negative_pin,
  input wire logic [acmp_pkg::LEVEL_W-1:0] bandgap_level,
  input wire logic [acmp_pkg::CHAN_N*acmp_pkg::LEVEL_W-1:0] channel_levels,
  input wire logic pos_pin_digital,
  input wire logic pos_pin_read,
  input wire logic neg_pin_read,
  input wire logic pos_pin_buffer_off,
  input wire logic neg_pin_buffer_off,
  input wire logic comp_power_off,
  input wire logic neg_channel_routed,
  input wire logic [acmp_pkg::CHAN_W-1:0] neg_channel,
  input wire logic bandgap_positive_select,
  input wire logic comp_result,
  input wire logic comp_irq_req,
  input wire logic capture_input
);
  import acmp_pkg::*;
  logic [LEVEL_W-1:0] sel_pos, sel_neg, pos_q, pin_q;
  logic [CHAN_N*LEVEL_W-1:0] lvl_q;
  logic off_q, raw_exp, meta_exp, res_exp, cap_on_q;
  // comparator, then two sync stages, rebuilt from the ports
  always_comb begin
    sel_pos = bandgap_positive_select ? bandgap_level : comp_positive_pin;
    sel_neg = neg_channel_routed ? lvl_q[int'(neg_channel)*LEVEL_W +: LEVEL_W] : pin_q;
    raw_exp = !off_q && (pos_q > sel_neg);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= '0;
      pin_q <= '0;
      lvl_q <= '0;
      off_q <= 1'h0;
      meta_exp <= 1'h0;
      res_exp <= 1'h0;
      cap_on_q <= 1'h0;
    end else begin
      pos_q <= sel_pos;
      pin_q <= comp_negative_pin;
      lvl_q <= channel_levels;
      off_q <= comp_power_off;
      meta_exp <= raw_exp;
      res_exp <= meta_exp;
      if (reg_wr && reg_addr == OFS_COMP_CTRL_STAT) begin
        cap_on_q <= reg_wdata[BIT_CAPTURE_ROUTE_EN];
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_result_settles: assert property (comp_result == res_exp)
    else $error("comparator result does not match selected inputs");
  a_power_off_quiet: assert property (comp_power_off [*4] |-> !comp_result)
    else $error("result high while comparator unpowered");
  a_route_needs_off: assert property (neg_channel_routed
    |-> !$past(converter_enable))
    else $error("channel routed while converter enabled");
  a_channel_follows: assert property (neg_channel_routed
    |-> neg_channel == $past(channel_select))
    else $error("routed channel differs from channel select");
  a_irq_needs_global: assert property (comp_irq_req |-> $past(global_irq_enable))
    else $error("irq request without global enable");
  a_vector_clears: assert property (comp_irq_vector_taken
    && !$changed(comp_result) |=> !comp_irq_req)
    else $error("vector did not clear the request");
  a_write_one_clears: assert property (reg_wr && reg_addr == OFS_COMP_CTRL_STAT
    && reg_wdata[BIT_COMP_EVENT_FLAG] && !$changed(comp_result) |=> !comp_irq_req)
    else $error("write one did not clear the request");
  a_capture_source: assert property (capture_input
    == ($past(cap_on_q) && $past(comp_result)))
    else $error("capture input differs from routed result");
  a_pins_gated: assert property (!(pos_pin_buffer_off && pos_pin_read)
    && !(neg_pin_buffer_off && neg_pin_read))
    else $error("pin read high while input buffer off");
  a_pin_passes: assert property (!pos_pin_buffer_off && !$past(rst)
    |-> pos_pin_read == $past(pos_pin_digital))
    else $error("pin read does not follow pin");
  c_irq: cover property ($rose(comp_irq_req));
  c_capture: cover property (capture_input);
  c_chan7: cover property (neg_channel_routed && neg_channel == 3'h7);
  c_vector: cover property (comp_irq_vector_taken && comp_irq_req);
endmodule
bind acmp_control acmp_control_chk chk_u (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .converter_enable, .channel_select, .global_irq_enable, .comp_irq_vector_taken,
  .comp_positive_pin, .comp_negative_pin, .bandgap_level, .channel_levels, .pos_pin_digital,
  .pos_pin_read, .neg_pin_read, .pos_pin_buffer_off, .neg_pin_buffer_off, .comp_power_off,
  .neg_channel_routed, .neg_channel, .bandgap_positive_select, .comp_result, .comp_irq_req,
  .capture_input);
`default_nettype wire

// >>> tb/acmp_front_model.sv
// analog front end and pin model
`timescale 1ns/10ps
`default_nettype none
module acmp_front_model #(
  parameter logic [9:0] BG_LEVEL = 10'h12C
) (
  input wire logic clock,
  input wire logic [9:0] pos_code,
  input wire logic [9:0] neg_code,
  output logic [9:0] comp_positive_pin,
  output logic [9:0] comp_negative_pin,
  output logic [9:0] bandgap_level,
  output logic [79:0] channel_levels,
  output logic pos_pin_digital,
  output logic neg_pin_digital
);
  // channel k sits at 100k+50
  always_comb begin
    bandgap_level = BG_LEVEL;
    for (int k = 0; k < 8; k++) begin
      channel_levels[k*10 +: 10] = 10'(k * 100 + 50);
    end
  end
  // levels settle one cycle after a change
  always_ff @(posedge clock) begin
    comp_positive_pin <= pos_code;
    comp_negative_pin <= neg_code;
    pos_pin_digital <= |pos_code[9:8];
    neg_pin_digital <= |neg_code[9:8];
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// testbench for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import acmp_pkg::*;
  typedef struct packed {
    logic bg;
    logic route;
    logic conv;
    logic [2:0] chan;
    logic [9:0] pos;
    logic res;
  } acmp_row_t;
  logic clock, rst, reg_wr, reg_rd, converter_enable, global_irq_enable, comp_irq_vector_taken;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [2:0] channel_select, neg_channel, trigger_source;
  logic [9:0] comp_positive_pin, comp_negative_pin, bandgap_level, pos_code, neg_code;
  logic [79:0] channel_levels;
  logic pos_pin_digital, neg_pin_digital, pos_pin_read, neg_pin_read, pos_pin_buffer_off;
  logic neg_pin_buffer_off, comp_power_off, neg_channel_routed, bandgap_positive_select;
  logic comp_result, comp_irq_req, capture_input, rt;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  acmp_row_t rows [13] = '{
    '{1'h0, 1'h0, 1'h0, 3'h0, 10'h1F4, 1'h1}, '{1'h0, 1'h0, 1'h0, 3'h0, 10'h190, 1'h0},
    '{1'h0, 1'h1, 1'h1, 3'h0, 10'h168, 1'h0}, '{1'h1, 1'h0, 1'h0, 3'h0, 10'h384, 1'h0},
    '{1'h1, 1'h1, 1'h0, 3'h2, 10'h000, 1'h1}, '{1'h0, 1'h1, 1'h0, 3'h0, 10'h168, 1'h1},
    '{1'h0, 1'h1, 1'h0, 3'h1, 10'h168, 1'h1}, '{1'h0, 1'h1, 1'h0, 3'h2, 10'h168, 1'h1},
    '{1'h0, 1'h1, 1'h0, 3'h3, 10'h168, 1'h1}, '{1'h0, 1'h1, 1'h0, 3'h4, 10'h168, 1'h0},
    '{1'h0, 1'h1, 1'h0, 3'h5, 10'h168, 1'h0}, '{1'h0, 1'h1, 1'h0, 3'h6, 10'h168, 1'h0},
    '{1'h0, 1'h1, 1'h0, 3'h7, 10'h168, 1'h0}};
  logic [3:0] up_exp = 4'h9;
  logic [3:0] dn_exp = 4'h5;
  acmp_control dut_u (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .converter_enable, .channel_select, .global_irq_enable, .comp_irq_vector_taken,
    .comp_positive_pin, .comp_negative_pin, .bandgap_level, .channel_levels, .pos_pin_digital,
    .neg_pin_digital, .pos_pin_read, .neg_pin_read, .pos_pin_buffer_off, .neg_pin_buffer_off,
    .comp_power_off, .neg_channel_routed, .neg_channel, .bandgap_positive_select,
    .trigger_source, .comp_result, .comp_irq_req, .capture_input);
  acmp_front_model #(.BG_LEVEL(10'h12C)) model_u (.clock, .pos_code, .neg_code,
    .comp_positive_pin, .comp_negative_pin, .bandgap_level, .channel_levels,
    .pos_pin_digital, .neg_pin_digital);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  // ----------------------------------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    rst = 1'h1; reg_wr = 1'h0; reg_rd = 1'h0; reg_addr = 2'h0; reg_wdata = 8'h00;
    converter_enable = 1'h0; channel_select = 3'h0; global_irq_enable = 1'h0;
    comp_irq_vector_taken = 1'h0; pos_code = 10'h000; neg_code = 10'h190;
    cyc(3);
    rst <= 1'h0;
    for (int r = 0; r < 4; r++) begin
      rd(2'(r), v);
      chk(v, 8'h00);
    end
    wr(OFS_MUX_TRIG_CTRL, 8'hFF);
    rd(OFS_MUX_TRIG_CTRL, v);
    chk(v, 8'h47);
    chk({5'h00, trigger_source}, 8'h07);
    wr(2'h3, 8'hFF);
    rd(2'h3, v);
    chk(v, 8'h00);
    foreach (rows[i]) begin
      wr(OFS_MUX_TRIG_CTRL, {1'h0, rows[i].route, 6'h00});
      wr(OFS_COMP_CTRL_STAT, {1'h0, rows[i].bg, 6'h00});
      converter_enable <= rows[i].conv; channel_select <= rows[i].chan; pos_code <= rows[i].pos;
      cyc(8);
      rd(OFS_COMP_CTRL_STAT, v);
      chk1(v[BIT_COMP_RESULT], rows[i].res);
      rt = rows[i].route && !rows[i].conv;
      v = {3'h0, bandgap_positive_select, neg_channel_routed, rt ? neg_channel : 3'h0};
      chk(v, {3'h0, rows[i].bg, rt, rt ? rows[i].chan : 3'h0});
    end
    wr(OFS_MUX_TRIG_CTRL, 8'h00); wr(OFS_COMP_CTRL_STAT, 8'h10); converter_enable <= 1'h0;
    for (int m = 0; m < 4; m++) begin
      pos_code <= 10'h000;
      cyc(8);
      wr(OFS_COMP_CTRL_STAT, {6'h04, 2'(m)});
      pos_code <= 10'h1F4;
      cyc(8);
      rd(OFS_COMP_CTRL_STAT, v);
      chk1(v[BIT_COMP_EVENT_FLAG], up_exp[m]);
      wr(OFS_COMP_CTRL_STAT, {6'h00, 2'(m)});
      rd(OFS_COMP_CTRL_STAT, v);
      chk1(v[BIT_COMP_EVENT_FLAG], up_exp[m]);
      wr(OFS_COMP_CTRL_STAT, {6'h04, 2'(m)});
      pos_code <= 10'h000;
      cyc(8);
      rd(OFS_COMP_CTRL_STAT, v);
      chk1(v[BIT_COMP_EVENT_FLAG], dn_exp[m]);
    end
    wr(OFS_COMP_CTRL_STAT, 8'h18);
    pos_code <= 10'h1F4;
    cyc(8);
    chk1(comp_irq_req, 1'h0);
    global_irq_enable <= 1'h1;
    cyc(2);
    chk1(comp_irq_req, 1'h1);
    comp_irq_vector_taken <= 1'h1;
    @(posedge clock);
    comp_irq_vector_taken <= 1'h0;
    cyc(1);
    chk1(comp_irq_req, 1'h0);
    pos_code <= 10'h000;
    cyc(8);
    chk1(comp_irq_req, 1'h1);
    wr(OFS_COMP_CTRL_STAT, 8'h18);
    cyc(1);
    chk1(comp_irq_req, 1'h0);
    wr(OFS_COMP_CTRL_STAT, 8'h04);
    pos_code <= 10'h1F4;
    cyc(8);
    chk1(capture_input, 1'h1);
    wr(OFS_COMP_CTRL_STAT, 8'h00);
    cyc(3);
    chk1(capture_input, 1'h0);
    wr(OFS_COMP_CTRL_STAT, 8'h80);
    cyc(8);
    chk1(comp_result, 1'h0);
    chk1(comp_power_off, 1'h1);
    wr(OFS_COMP_CTRL_STAT, 8'h00);
    chk({6'h00, pos_pin_read, neg_pin_read}, 8'h03);
    wr(OFS_DIG_IN_DISABLE, 8'hFF);
    rd(OFS_DIG_IN_DISABLE, v);
    chk(v, 8'h03);
    v = {4'h0, pos_pin_buffer_off, neg_pin_buffer_off, pos_pin_read, neg_pin_read};
    chk(v, 8'h0C);
    // mid-run reset
    @(posedge clock);
    rst <= 1'h1;
    cyc(2);
    chk({6'h00, pos_pin_buffer_off, neg_pin_buffer_off}, 8'h00);
    rst <= 1'h0;
    rd(OFS_DIG_IN_DISABLE, v);
    chk(v, 8'h00);
    chk({6'h00, pos_pin_read, neg_pin_read}, 8'h03);
    stop_test();
  end
endmodule
`default_nettype wire
